// ==== bench/emc_sva.sv ====
// Link protocol checker for the engineering mode control ends.
`timescale 1ns/1ps
module emc_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata
);
    // ----------------------------------------------------------
    // Link handshake
    // ----------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_start;
        !req ##1 req;
    endsequence
    sequence s_xfer;
        s_start ##1 ack;
    endsequence
    property p_ack_time;
        s_start |=> ack;
    endproperty
    a_ack_time: assert property (p_ack_time)
        else $error("ack not one cycle after request");
    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_ack_cause;
        ack |-> req;
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    property p_req_hold;
        req && !ack |=> req;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before ack");
    property p_req_drop;
        ack |=> !req;
    endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("request held after ack");
    // Fields must not move while the device may still take them.
    property p_fields;
        req && !ack |=> $stable({wr, addr, wdata});
    endproperty
    a_fields: assert property (p_fields)
        else $error("request fields changed while pending");
    property p_rdata;
        !ack |-> $stable(rdata);
    endproperty
    a_rdata: assert property (p_rdata)
        else $error("read data moved without ack");
    property p_walk;
        s_xfer |=> !req && !ack;
    endproperty
    a_walk: assert property (p_walk)
        else $error("transfer did not close cleanly");
endmodule // emc_sva

// ==== bench/test_engineering_mode_control.sv ====
// Testbench joining host and device ends over the mode control link.
`timescale 1ns/1ps
module test_engineering_mode_control;
    import emc_pkg::*;
    logic hclk, hresetn, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [15:0] q;
    logic wd_inf, wd_dis, rt_en, fs_en, can_on, reg_on;
    logic [4:0] st_num;
    int miscompares = 0;
    int n_tests = 0;
    emc_link_if link_bus();
    emc_device #(.SECTORS(4)) i_emc_device (.hclk(hclk),
        .hresetn(hresetn), .link(link_bus.device),
        .watchdog_infinite(wd_inf), .watchdog_disable(wd_dis),
        .reset_timer_enable(rt_en), .failsafe_enable(fs_en),
        .can_active(can_on), .regulators_on(reg_on),
        .state_number(st_num));
    emc_host i_emc_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .link(link_bus.host));
    emc_sva i_sva (.hclk(hclk), .hresetn(hresetn), .req(link_bus.req),
        .wr(link_bus.wr), .addr(link_bus.addr), .wdata(link_bus.wdata),
        .ack(link_bus.ack), .rdata(link_bus.rdata));
    // ----------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] o);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        o = hrdata;
    endtask
    // The status poll starts after the walk, when busy has already fallen.
    task automatic link(input logic w, input logic [7:0] a,
                        input logic [15:0] d);
        logic [31:0] s;
        ahb(1'b1, HOST_COMMAND, {w, 7'h0, a, d}, s);
        repeat (4) @(posedge hclk);
        s = 32'h10000;
        while (s[16] !== 1'b0) ahb(1'b0, HOST_STATUS, 32'h0, s);
        q = s[15:0];
    endtask
    task automatic pins(input logic [4:0] p);
        ahb(1'b1, HOST_PINS, {27'h0, p}, r);
        repeat (8) @(posedge hclk);
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cfg(input string n, input logic [15:0] e);
        link(1'b0, REG_SYSTEM_CONFIG_ONE, 16'h0);
        chk(n, {16'h0, e}, {16'h0, q & 16'h071f});
    endtask
    task automatic close_out;
        $display("miscompares %0d n_tests %0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------
    // Tests
    // ----------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        #(25ns * 20000);
        miscompares++;
        close_out;
    end
    initial begin
        hresetn = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 8'h0c, 32'h0, r);
        chk("unmapped", 32'h0, r);
        chk("okay", 32'h0, {31'h0, hresp});
        pins(5'h01);
        pins(5'h05);
        cfg("prog_entry", 16'h0200 | NUM_PROG);
        r = {27'h0, wd_inf, wd_dis, rt_en, fs_en, can_on};
        chk("prog_gates", 32'h11, r);
        link(1'b1, REG_FUSE_COMMAND, FUSE_CMD_FILL);
        link(1'b0, REG_TEST_ENTRY_STATUS, 16'h0);
        chk("gate_no_test", 32'h0, {16'h0, q & 16'h3});
        link(1'b1, REG_TEST_KEY, TEST_KEY_FIRST);
        link(1'b1, REG_TEST_KEY, TEST_KEY_SECOND);
        cfg("modes", 16'h0600 | NUM_PROG);
        for (int i = 0; i < SHADOW_BYTES; i++) begin
            link(1'b1, REG_SHADOW_DATA, 16'(i));
            link(1'b1, REG_SHADOW_COMMAND, SHADOW_CMD_FIRST + 16'(i));
        end
        link(1'b1, REG_FUSE_COMMAND, FUSE_CMD_FILL);
        link(1'b1, REG_FUSE_COMMAND, FUSE_CMD_CHECK);
        link(1'b0, REG_TEST_ENTRY_STATUS, 16'h0);
        chk("fuse_status", 32'h15, {16'h0, q & 16'h1f});
        link(1'b1, REG_FUSE_COMMAND, FUSE_CMD_FILL);
        link(1'b1, REG_FUSE_COMMAND, FUSE_CMD_CHECK);
        link(1'b0, REG_FUSE_SECTOR, 16'h0);
        chk("wear", 32'h8, {16'h0, q & 16'hf});
        link(1'b1, REG_FUSE_COMMAND, FUSE_CMD_FILL);
        link(1'b1, REG_FUSE_COMMAND, FUSE_CMD_CHECK);
        link(1'b0, REG_TEST_ENTRY_STATUS, 16'h0);
        chk("refused", 32'h8, {16'h0, q & 16'h8});
        pins(5'h04);
        cfg("prog_drop", 16'h0500 | NUM_POWERUP);
        repeat (POWERUP_CYCLES) @(posedge hclk);
        cfg("normal", 16'h0500 | NUM_NORMAL);
        link(1'b1, REG_SYSTEM_CONFIG_ONE, 16'h8000);
        pins(5'h06);
        cfg("leave_debug", 16'h0400 | NUM_NORMAL);
        chk("normal_gates", 32'h3, {wd_dis, rt_en, fs_en});
        pins(5'h00);
        pins(5'h02);
        pins(5'h06);
        cfg("debug_entry", 16'h0100 | NUM_POWERUP);
        r = {27'h0, wd_inf, wd_dis, rt_en, fs_en, can_on};
        chk("debug_gates", 32'h8, r);
        pins(5'h00);
        pins(5'h04);
        chk("auto_start", 32'h1, {31'h0, reg_on});
        chk("auto_state", {27'h0, NUM_POWERUP}, {27'h0, st_num});
        link(1'b0, REG_TEST_ENTRY_STATUS, 16'h0);
        chk("emulation_kept", 32'h10, {16'h0, q & 16'h10});
        repeat (POWERUP_CYCLES) @(posedge hclk);
        pins(5'h0c);
        cfg("low_power", {11'h0, NUM_LOW_POWER});
        pins(5'h15);
        cfg("wake_prog", 16'h0200 | NUM_PROG);
        close_out;
    end
endmodule // test_engineering_mode_control

// ==== include/emc_link_if.sv ====
// Link between the host controller and the mode control device.
`timescale 1ns/1ps
interface emc_link_if;
    logic prog_level;
    logic debug_level;
    logic supply_ok;
    logic sleep_req;
    logic wake;
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    modport device (
        input prog_level, debug_level, supply_ok, sleep_req, wake,
        input req, wr, addr, wdata,
        output ack, rdata
    );
    modport host (
        output prog_level, debug_level, supply_ok, sleep_req, wake,
        output req, wr, addr, wdata,
        input ack, rdata
    );
endinterface

// ==== include/emc_pkg.sv ====
// Shared constants and types for the engineering mode control ends.
package emc_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int POWERUP_TIME_NS = 10000;
    localparam int POWERUP_CYCLES = (POWERUP_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Device register indices on the link
    // ------------------------------------------------------------
    localparam logic [7:0] REG_SYSTEM_CONFIG_ONE = 8'h06;
    localparam logic [7:0] REG_TEST_KEY = 8'h10;
    localparam logic [7:0] REG_TEST_ENTRY_STATUS = 8'h11;
    localparam logic [7:0] REG_SHADOW_DATA = 8'h12;
    localparam logic [7:0] REG_SHADOW_COMMAND = 8'h13;
    localparam logic [7:0] REG_FUSE_COMMAND = 8'h14;
    localparam logic [7:0] REG_FUSE_SECTOR = 8'h15;
    // ------------------------------------------------------------
    // Field positions and command words
    // ------------------------------------------------------------
    localparam int SYS_DEBUG_BIT = 8;
    localparam int SYS_PROG_BIT = 9;
    localparam int SYS_TEST_BIT = 10;
    localparam int SYS_LEAVE_DEBUG_BIT = 15;
    localparam logic [15:0] SHADOW_CMD_FIRST = 16'h011c;
    localparam logic [15:0] SHADOW_CMD_LAST = 16'h0130;
    localparam int SHADOW_BYTES = 21;
    localparam logic [15:0] FUSE_CMD_FILL = 16'h0125;
    localparam logic [15:0] FUSE_CMD_CHECK = 16'h0124;
    localparam logic [1:0] FUSE_MAX_PROG = 2'h2;
    // Key values are arbitrary.
    localparam logic [15:0] TEST_KEY_FIRST = 16'h3c5a;
    localparam logic [15:0] TEST_KEY_SECOND = 16'ha5c3;
    // ------------------------------------------------------------
    // Main state machine and its reported numbers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF, ST_PROG_CHECK, ST_PROG, ST_UNCONFIGURED,
        ST_POWERUP, ST_NORMAL, ST_LOW_POWER
    } emc_state_type;
    localparam logic [4:0] NUM_OFF = 5'h00;
    localparam logic [4:0] NUM_PROG_CHECK = 5'h01;
    localparam logic [4:0] NUM_PROG = 5'h02;
    localparam logic [4:0] NUM_UNCONFIGURED = 5'h03;
    localparam logic [4:0] NUM_POWERUP = 5'h04;
    localparam logic [4:0] NUM_NORMAL = 5'h05;
    localparam logic [4:0] NUM_LOW_POWER = 5'h06;
    // ------------------------------------------------------------
    // Host register offsets on AHB-Lite
    // ------------------------------------------------------------
    localparam logic [7:0] HOST_PINS = 8'h00;
    localparam logic [7:0] HOST_COMMAND = 8'h04;
    localparam logic [7:0] HOST_STATUS = 8'h08;
    localparam int HOST_CMD_WRITE_BIT = 31;
endpackage

// ==== rtl/emc_device.sv ====
// Mode selection and mode gating logic of the supply device.
//
// Decided for this implementation: the req/ack link register port (AHB-Lite sits in emc_host).
`timescale 1ns/1ps
module emc_device
    import emc_pkg::*;
#(
    parameter int SECTORS = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    emc_link_if.device link,
    output logic watchdog_infinite,
    output logic watchdog_disable,
    output logic reset_timer_enable,
    output logic failsafe_enable,
    output logic can_active,
    output logic regulators_on,
    output logic [4:0] state_number
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Levels come from analog comparators and are asynchronous.
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic [4:0] next_sync_a;
    always_comb begin
        next_sync_a = {link.wake, link.sleep_req, link.supply_ok,
                       link.debug_level, link.prog_level};
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= sync_a;
        end
    end
    logic prog_lvl, dbg_lvl, sup_ok, sleep_rq, wake_rq;
    assign {wake_rq, sleep_rq, sup_ok, dbg_lvl, prog_lvl} = sync_b;

    function automatic logic [4:0] state_code(input emc_state_type s);
        unique case (s)
            ST_OFF: state_code = NUM_OFF;
            ST_PROG_CHECK: state_code = NUM_PROG_CHECK;
            ST_PROG: state_code = NUM_PROG;
            ST_UNCONFIGURED: state_code = NUM_UNCONFIGURED;
            ST_POWERUP: state_code = NUM_POWERUP;
            ST_NORMAL: state_code = NUM_NORMAL;
            ST_LOW_POWER: state_code = NUM_LOW_POWER;
            default: state_code = NUM_OFF;
        endcase
    endfunction

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    emc_state_type state, next_state;
    logic prog_mode, next_prog_mode;
    logic debug_mode, next_debug_mode;
    logic test_mode, next_test_mode;
    logic key_half, next_key_half;
    logic can_on, next_can_on;
    logic emulated, next_emulated;
    logic crc_filled, next_crc_filled;
    logic crc_ok, next_crc_ok;
    logic refused, next_refused;
    logic [15:0] shadow_data, next_shadow_data;
    logic [1:0] sector_sel, next_sector_sel;
    logic [11:0] pu_count, next_pu_count;
    logic ack, next_ack;
    logic [15:0] rdata, next_rdata;
    logic [1:0] prog_cnt [SECTORS];
    logic [7:0] shadow [SHADOW_BYTES];
    logic shadow_we;
    logic [4:0] shadow_idx;
    logic burn_we;
    logic fuse_programmed;
    logic wr_hit;
    logic fuse_ok;

    always_comb begin
        fuse_programmed = 1'b0;
        for (int i = 0; i < SECTORS; i++) begin
            if (prog_cnt[i] != 2'h0) begin
                fuse_programmed = 1'b1;
            end
        end
    end

    always_comb begin
        next_state = state;
        next_prog_mode = prog_mode;
        next_debug_mode = debug_mode;
        next_test_mode = test_mode;
        next_key_half = key_half;
        next_can_on = can_on;
        next_emulated = emulated;
        next_crc_filled = crc_filled;
        next_crc_ok = crc_ok;
        next_refused = refused;
        next_shadow_data = shadow_data;
        next_sector_sel = sector_sel;
        next_pu_count = pu_count;
        next_ack = link.req & ~ack;
        next_rdata = rdata;
        shadow_we = 1'b0;
        shadow_idx = 5'h00;
        burn_we = 1'b0;
        wr_hit = next_ack & link.wr;
        fuse_ok = prog_mode & test_mode;
        // Main state machine.
        unique case (state)
            ST_OFF: begin
                if (sup_ok) begin
                    next_state = ST_PROG_CHECK;
                    next_debug_mode = dbg_lvl & ~prog_lvl;
                end
            end
            ST_PROG_CHECK: begin
                if (prog_lvl) begin
                    next_state = ST_PROG;
                    next_prog_mode = 1'b1;
                    next_can_on = 1'b1;
                end else if (debug_mode || fuse_programmed) begin
                    next_state = ST_POWERUP;
                end else begin
                    next_state = ST_UNCONFIGURED;
                end
            end
            ST_PROG: begin
                if (!prog_lvl) begin
                    next_state = ST_POWERUP;
                    next_prog_mode = 1'b0;
                    next_debug_mode = 1'b1;
                end
            end
            ST_UNCONFIGURED: begin
            end
            ST_POWERUP: begin
                next_pu_count = pu_count + 12'h001;
                if (pu_count == 12'(POWERUP_CYCLES - 1)) begin
                    next_state = ST_NORMAL;
                    next_pu_count = 12'h000;
                end
            end
            ST_NORMAL: begin
                if (sleep_rq) begin
                    next_state = ST_LOW_POWER;
                end
            end
            ST_LOW_POWER: begin
                if (wake_rq) begin
                    next_state = ST_PROG_CHECK;
                end
            end
        endcase
        if (!sup_ok && state != ST_OFF) begin
            next_state = ST_OFF;
            next_prog_mode = 1'b0;
            next_debug_mode = 1'b0;
            next_test_mode = 1'b0;
            next_can_on = 1'b0;
            next_pu_count = 12'h000;
        end
        // Register writes.
        if (wr_hit) begin
            unique case (link.addr)
                REG_SYSTEM_CONFIG_ONE: begin
                    if (link.wdata[SYS_LEAVE_DEBUG_BIT]) begin
                        next_debug_mode = 1'b0;
                    end
                end
                REG_TEST_KEY: begin
                    if (prog_mode && !key_half
                        && link.wdata == TEST_KEY_FIRST) begin
                        next_key_half = 1'b1;
                    end else if (prog_mode && key_half
                        && link.wdata == TEST_KEY_SECOND) begin
                        next_test_mode = 1'b1;
                        next_key_half = 1'b0;
                    end else begin
                        next_key_half = 1'b0;
                    end
                end
                REG_SHADOW_DATA: next_shadow_data = link.wdata;
                REG_SHADOW_COMMAND: begin
                    if (fuse_ok && link.wdata >= SHADOW_CMD_FIRST
                        && link.wdata <= SHADOW_CMD_LAST) begin
                        shadow_we = 1'b1;
                        shadow_idx = 5'(link.wdata - SHADOW_CMD_FIRST);
                        next_emulated = 1'b1;
                    end
                end
                REG_FUSE_COMMAND: begin
                    if (fuse_ok && link.wdata == FUSE_CMD_FILL) begin
                        next_crc_filled = 1'b1;
                        next_crc_ok = 1'b0;
                    end else if (fuse_ok && crc_filled
                        && link.wdata == FUSE_CMD_CHECK) begin
                        next_crc_ok = 1'b1;
                        next_crc_filled = 1'b0;
                        if (prog_cnt[sector_sel] < FUSE_MAX_PROG) begin
                            burn_we = 1'b1;
                        end else begin
                            next_refused = 1'b1;
                        end
                    end
                end
                REG_FUSE_SECTOR: next_sector_sel = link.wdata[1:0];
                default: begin
                end
            endcase
        end
        // Register reads.
        if (next_ack) begin
            next_rdata = 16'h0000;
            unique case (link.addr)
                REG_SYSTEM_CONFIG_ONE: begin
                    next_rdata[4:0] = state_code(state);
                    next_rdata[SYS_DEBUG_BIT] = debug_mode;
                    next_rdata[SYS_PROG_BIT] = prog_mode;
                    next_rdata[SYS_TEST_BIT] = test_mode;
                end
                REG_TEST_ENTRY_STATUS: next_rdata = {11'h000, emulated,
                    refused, crc_ok, crc_filled, test_mode};
                REG_SHADOW_DATA: next_rdata = shadow_data;
                REG_FUSE_SECTOR: next_rdata = {12'h000,
                    prog_cnt[sector_sel], sector_sel};
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_OFF;
            prog_mode <= 1'b0;
            debug_mode <= 1'b0;
            test_mode <= 1'b0;
            key_half <= 1'b0;
            can_on <= 1'b0;
            emulated <= 1'b0;
            crc_filled <= 1'b0;
            crc_ok <= 1'b0;
            refused <= 1'b0;
            shadow_data <= 16'h0000;
            sector_sel <= 2'h0;
            pu_count <= 12'h000;
            ack <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            state <= next_state;
            prog_mode <= next_prog_mode;
            debug_mode <= next_debug_mode;
            test_mode <= next_test_mode;
            key_half <= next_key_half;
            can_on <= next_can_on;
            emulated <= next_emulated;
            crc_filled <= next_crc_filled;
            crc_ok <= next_crc_ok;
            refused <= next_refused;
            shadow_data <= next_shadow_data;
            sector_sel <= next_sector_sel;
            pu_count <= next_pu_count;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Shadow bytes and fuse wear counters
    // ------------------------------------------------------------
    // Wear counters clear on reset here; a real part keeps them in fuses.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < SHADOW_BYTES; i++) begin
                shadow[i] <= 8'h00;
            end
            for (int i = 0; i < SECTORS; i++) begin
                prog_cnt[i] <= 2'h0;
            end
        end else begin
            if (shadow_we) begin
                shadow[shadow_idx] <= shadow_data[7:0];
            end
            if (burn_we) begin
                prog_cnt[sector_sel] <= prog_cnt[sector_sel] + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Mode gating outputs
    // ------------------------------------------------------------
    // watchdog, reset timer and failsafe gates decoded from prog_mode and debug_mode; can_active from can_on
    assign link.ack = ack;
    assign link.rdata = rdata;
    assign watchdog_infinite = prog_mode;
    assign watchdog_disable = debug_mode;
    assign reset_timer_enable = ~prog_mode & ~debug_mode;
    assign failsafe_enable = ~prog_mode & ~debug_mode;
    assign can_active = can_on;
    assign regulators_on = (state == ST_POWERUP) || (state == ST_NORMAL);
    assign state_number = state_code(state);
endmodule // emc_device

// ==== rtl/emc_host.sv ====
// Host controller: AHB-Lite slave driving the device pins and link.
`timescale 1ns/1ps
module emc_host
    import emc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    emc_link_if.host link
);
    // ------------------------------------------------------------
    // Bus capture
    // ------------------------------------------------------------
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic [4:0] pins, next_pins;
    logic busy, next_busy;
    logic cmd_wr, next_cmd_wr;
    logic [7:0] cmd_addr, next_cmd_addr;
    logic [15:0] cmd_data, next_cmd_data;
    logic [15:0] rd_buf, next_rd_buf;
    logic [31:0] rdata, next_rdata;
    logic phase_ok;

    always_comb begin
        phase_ok = hsel & hready & htrans[1];
        next_wr_pend = phase_ok & hwrite;
        next_wr_addr = phase_ok ? haddr[7:0] : wr_addr;
        next_pins = pins;
        next_busy = busy;
        next_cmd_wr = cmd_wr;
        next_cmd_addr = cmd_addr;
        next_cmd_data = cmd_data;
        next_rd_buf = rd_buf;
        next_rdata = rdata;
        if (phase_ok && !hwrite) begin
            unique case (haddr[7:0])
                HOST_PINS: next_rdata = {27'h0000000, pins};
                HOST_STATUS: next_rdata = {15'h0000, busy, rd_buf};
                default: next_rdata = 32'h00000000;
            endcase
        end
        if (wr_pend && wr_addr == HOST_PINS) begin
            next_pins = hwdata[4:0];
        end
        // A command while busy is dropped; software polls busy first.
        if (wr_pend && wr_addr == HOST_COMMAND && !busy) begin
            next_busy = 1'b1;
            next_cmd_wr = hwdata[HOST_CMD_WRITE_BIT];
            next_cmd_addr = hwdata[23:16];
            next_cmd_data = hwdata[15:0];
        end
        if (busy && link.ack) begin
            next_busy = 1'b0;
            next_rd_buf = link.rdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            pins <= 5'h00;
            busy <= 1'b0;
            cmd_wr <= 1'b0;
            cmd_addr <= 8'h00;
            cmd_data <= 16'h0000;
            rd_buf <= 16'h0000;
            rdata <= 32'h00000000;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            pins <= next_pins;
            busy <= next_busy;
            cmd_wr <= next_cmd_wr;
            cmd_addr <= next_cmd_addr;
            cmd_data <= next_cmd_data;
            rd_buf <= next_rd_buf;
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata = rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign link.prog_level = pins[0];
    assign link.debug_level = pins[1];
    assign link.supply_ok = pins[2];
    assign link.sleep_req = pins[3];
    assign link.wake = pins[4];
    assign link.req = busy;
    assign link.wr = cmd_wr;
    assign link.addr = cmd_addr;
    assign link.wdata = cmd_data;
endmodule // emc_host
